// ---- bench/pp_port_write_protect_asserts.sv ----
// Checker for the parallel programming port pins
`timescale 1ns/1ps
module pp_port_write_protect_asserts
  import pp_port_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Port pins
  input wire logic [ADDR_PIN_W-1:0] mux_addr_pins_i,
  input wire logic row_col_sel_i,
  input wire logic out_en_n_i,
  input wire logic wr_en_n_i,
  input wire logic top_boot_lock_n_i,
  input wire logic gen_wp_n_i,
  input wire logic [DATA_W-1:0] byte_data_lines_i,
  input wire logic [DATA_W-1:0] byte_data_lines_o,
  input wire logic byte_data_lines_oe_o,
  // Core side
  input wire logic [FULL_ADDR_W-1:0] rd_addr_o,
  input wire logic [DATA_W-1:0] rd_data_i,
  input wire logic prog_valid_o,
  input wire prog_req_t prog_req_o,
  input wire logic prog_refused_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  // Request aims at the top block
  logic top_blk;
  assign top_blk = prog_req_o.addr[18:16] == 3'h7;
  a_oe_lag: assert property (
    byte_data_lines_oe_o == !$past(out_en_n_i, 3)) else $error("enable lag wrong");
  a_tri_idle: assert property (
    out_en_n_i [*4] |-> !byte_data_lines_oe_o) else $error("drives while disabled");
  a_core_data: assert property (
    byte_data_lines_oe_o |-> byte_data_lines_o == $past(rd_data_i)) else $error("read data");
  a_row_latch: assert property (
    $fell(row_col_sel_i) |-> ##5 rd_addr_o[18:11] == $past(mux_addr_pins_i[7:0], 5))
    else $error("row half wrong");
  a_col_latch: assert property (
    $rose(row_col_sel_i) |-> ##5 rd_addr_o[10:0] == $past(mux_addr_pins_i, 5))
    else $error("column half wrong");
  a_wr_answer: assert property (
    $rose(wr_en_n_i) |-> ##[3:5] (prog_valid_o || prog_refused_o)) else $error("no answer");
  a_wr_data: assert property (
    prog_valid_o || prog_refused_o |-> prog_req_o.data == $past(byte_data_lines_i, 3))
    else $error("write data");
  a_top_lock: assert property (
    prog_valid_o |-> !(top_blk && !top_boot_lock_n_i)) else $error("top lock ignored");
  a_wp_block: assert property (
    prog_valid_o |-> (top_blk || gen_wp_n_i)) else $error("protect ignored");
  a_refuse_why: assert property (
    prog_refused_o |-> (top_blk ? !top_boot_lock_n_i : !gen_wp_n_i)) else $error("bad refusal");
endmodule

// ---- bench/prog_equip.sv ----
// Programming equipment model driving the port pins
`timescale 1ns/1ps
module prog_equip (
  // Clock
  input wire logic mclk_i,
  // Pins toward the port
  output logic [10:0] addr_o,
  output logic rcs_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [7:0] data_o
);
  // Idle levels
  initial begin
    addr_o = 11'h000;
    rcs_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    data_o = 8'h5A;
  end
  // Wait clock edges
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic set_oe(input logic n);
    oe_n_o <= n;
  endtask
  task automatic set_addr(input logic [7:0] row, input logic [10:0] col);
    cyc(1);
    addr_o <= {3'h0, row};
    cyc(4);
    rcs_o <= 1'b0;
    cyc(4);
    addr_o <= col;
    cyc(4);
    rcs_o <= 1'b1;
    cyc(5);
  endtask
  task automatic wr(input logic [7:0] d);
    we_n_o <= 1'b0;
    cyc(4);
    data_o <= d;
    cyc(4);
    we_n_o <= 1'b1;
    fork
      begin
        cyc(5);
        data_o <= ~d;
      end
    join_none
  endtask
endmodule

// ---- bench/tb.sv ----
// Testbench for the parallel programming port
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value %0t %h %h", $time, a, b); end end
module tb;
  import pp_port_pkg::*;
  // Clock, reset and pins
  logic mclk_i = 0, rstn_i = 0, tbl_n = 1, wp_n = 1;
  logic [10:0] addr;
  logic rcs, oe_n, we_n, dut_oe, pv, pref;
  logic [7:0] pe_d, dut_d, line, rd_data = 8'h00;
  logic [18:0] rd_addr;
  prog_req_t preq;
  int bad_count = 0, n_checks = 0;
  // Data wire resolved from both drivers
  assign line = dut_oe ? dut_d : pe_d;
  initial forever #20 mclk_i = ~mclk_i;
  // Core read data follows the address
  always @(posedge mclk_i) rd_data <= rd_addr[7:0] ^ 8'h3C;
  prog_equip pe_i (.mclk_i, .addr_o(addr), .rcs_o(rcs), .oe_n_o(oe_n), .we_n_o(we_n),
    .data_o(pe_d));
  pp_port_write_protect pp_port_write_protect_i (.mclk_i, .rstn_i, .mux_addr_pins_i(addr),
    .row_col_sel_i(rcs), .out_en_n_i(oe_n), .wr_en_n_i(we_n), .top_boot_lock_n_i(tbl_n),
    .gen_wp_n_i(wp_n), .byte_data_lines_i(line), .byte_data_lines_o(dut_d),
    .byte_data_lines_oe_o(dut_oe), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .prog_valid_o(pv), .prog_req_o(preq), .prog_refused_o(pref));
  // Report and end the run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Read with enable low, then release
  task automatic t_read;
    pe_i.set_addr(8'h5A, 11'h6C1);
    `CHK(rd_addr, 19'h2D6C1)
    pe_i.set_oe(1'b0);
    pe_i.cyc(5);
    `CHK(dut_oe, 1'b1)
    `CHK(line, 8'hFD)
    pe_i.set_oe(1'b1);
    pe_i.cyc(5);
    `CHK(dut_oe, 1'b0)
    $display("read test done");
  endtask
  // Program one byte under given protect levels
  task automatic t_prog(input logic [7:0] row, input logic l, w, r);
    int i;
    tbl_n <= l;
    wp_n <= w;
    pe_i.set_addr(row, 11'h123);
    pe_i.wr(row ^ 8'h96);
    i = 0;
    while (pv !== 1'b1 && pref !== 1'b1) begin
      @(negedge mclk_i);
      i++;
      if (i > 12) begin
        bad_count++;
        print_verdict;
      end
    end
    `CHK(pref, r)
    `CHK(pv, ~r)
    `CHK(preq, {row, 11'h123, row ^ 8'h96})
    pe_i.cyc(5);
    $display("program test done");
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_read;
    t_prog(8'hE0, 1'b0, 1'b1, 1'b1);
    t_prog(8'hE0, 1'b1, 1'b0, 1'b0);
    t_prog(8'h01, 1'b1, 1'b0, 1'b1);
    t_prog(8'h01, 1'b0, 1'b1, 1'b0);
    print_verdict;
  end
endmodule
bind pp_port_write_protect pp_port_write_protect_asserts chk_i (.mclk_i, .rstn_i,
  .mux_addr_pins_i, .row_col_sel_i, .out_en_n_i, .wr_en_n_i, .top_boot_lock_n_i,
  .gen_wp_n_i, .byte_data_lines_i, .byte_data_lines_o, .byte_data_lines_oe_o, .rd_addr_o,
  .rd_data_i, .prog_valid_o, .prog_req_o, .prog_refused_o);

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Asynchronous pins and their synchronised copy
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // First stage, read only by the second stage
  logic [W-1:0] meta_ff;

  // Two flip-flops in series
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_o <= meta_ff;
    end
  end

endmodule

// ---- rtl/pp_port_pkg.sv ----
// Shared constants and carrier types for the parallel programming port
package pp_port_pkg;

  // Pin group widths
  localparam int unsigned ADDR_PIN_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ROW_W = 8;
  localparam int unsigned FULL_ADDR_W = ROW_W + ADDR_PIN_W;

  // Number of pin bits that pass the synchroniser
  localparam int unsigned SYNC_W = ADDR_PIN_W + DATA_W + 5;

  // Block number field within the full address
  localparam int unsigned BLOCK_LSB = 16;
  localparam int unsigned BLOCK_W = 3;
  localparam logic [BLOCK_W-1:0] TOP_BLOCK = 3'h7;

  // Values after reset
  localparam logic [ADDR_PIN_W-1:0] ADDR_PIN_RST = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [FULL_ADDR_W-1:0] FULL_ADDR_RST = 19'h00000;

  // Write cycle tracking states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_LOW = 2'b10
  } wr_state_t;

  // Program request handed to the memory core
  typedef struct packed {
    logic [FULL_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } prog_req_t;

endpackage

// ---- rtl/pp_port_write_protect.sv ----
// Parallel programming port with multiplexed address and hardware write protect
//
// Overview of operation
// - Top boot lock low refuses top-block programs
// - Top boot lock high lifts top protection
// - Write-protect low blocks all but top block
// - Row/column select chooses row or column half
// - Address pins latched into row/column latches
// - Data lines out on read, in on write
// - Output enable high leaves data lines undriven
// - Drivers follow output enable low three clocks late, and stay on three clocks after it rises
`timescale 1ns/1ps
module pp_port_write_protect (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Multiplexed address pins and strobes
  input wire logic [pp_port_pkg::ADDR_PIN_W-1:0] mux_addr_pins_i,
  input wire logic row_col_sel_i,
  input wire logic out_en_n_i,
  input wire logic wr_en_n_i,
  // Hardware write protect pins
  input wire logic top_boot_lock_n_i,
  input wire logic gen_wp_n_i,
  // Two-way data pins
  input wire logic [pp_port_pkg::DATA_W-1:0] byte_data_lines_i,
  output logic [pp_port_pkg::DATA_W-1:0] byte_data_lines_o,
  output logic byte_data_lines_oe_o,
  // Memory core read side
  output logic [pp_port_pkg::FULL_ADDR_W-1:0] rd_addr_o,
  input wire logic [pp_port_pkg::DATA_W-1:0] rd_data_i,
  // Memory core program side
  output logic prog_valid_o,
  output pp_port_pkg::prog_req_t prog_req_o,
  output logic prog_refused_o
);

  import pp_port_pkg::*;

  // Synchronised pin copies
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic [ADDR_PIN_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic rc_s;
  logic oe_n_s;
  logic we_n_s;
  logic tbl_n_s;
  logic wp_n_s;

  // Previous strobe levels for edge detection
  logic rc_prev_ff;
  logic we_prev_ff;

  // Address latches
  logic [ADDR_PIN_W-1:0] row_ff;
  logic [ADDR_PIN_W-1:0] col_ff;
  logic [FULL_ADDR_W-1:0] full_addr;

  // Write cycle state and held write address
  wr_state_t wr_state_ff;
  wr_state_t nxt_wr_state;
  logic [FULL_ADDR_W-1:0] wr_addr_ff;

  // Protection decision for the held write address
  logic top_hit;
  logic blocked;

  // Strobe edges
  logic rc_fall;
  logic rc_rise;
  logic we_fall;
  logic we_rise;

  // Gather all pins for one synchroniser; strobes idle high at reset
  assign pins_async = {mux_addr_pins_i, byte_data_lines_i, row_col_sel_i,
                       out_en_n_i, wr_en_n_i, top_boot_lock_n_i, gen_wp_n_i};

  // Every pin passes two flip-flops before use
  pin_sync #(
    .W(SYNC_W),
    .RST_VAL({ADDR_PIN_RST, DATA_RST, 5'h1F})
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  // Split the synchronised vector
  assign {addr_s, data_s, rc_s, oe_n_s, we_n_s, tbl_n_s, wp_n_s} = pins_sync;

  // Edges of the select and write strobes
  assign rc_fall = rc_prev_ff & ~rc_s;
  assign rc_rise = ~rc_prev_ff & rc_s;
  assign we_fall = we_prev_ff & ~we_n_s;
  assign we_rise = ~we_prev_ff & we_n_s;

  // Full address: low row bits above the column half
  assign full_addr = {row_ff[ROW_W-1:0], col_ff};

  // Strobe history
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rc_prev_ff <= 1'b1;
      we_prev_ff <= 1'b1;
    end else begin
      rc_prev_ff <= rc_s;
      we_prev_ff <= we_n_s;
    end
  end

  // Row and column latches
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      row_ff <= ADDR_PIN_RST;
      col_ff <= ADDR_PIN_RST;
    end else begin
      if (rc_fall) begin
        // Select driven low: pins carry the row half
        row_ff <= addr_s;
      end
      if (rc_rise) begin
        // Select driven high: pins carry the column half
        col_ff <= addr_s;
      end
    end
  end

  // Read address presented to the core
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_addr_o <= FULL_ADDR_RST;
    end else begin
      rd_addr_o <= full_addr;
    end
  end

  // Next write state
  always_comb begin
    nxt_wr_state = wr_state_ff;
    case (wr_state_ff)
      WR_IDLE: begin
        if (we_fall) begin
          nxt_wr_state = WR_LOW;
        end
      end
      WR_LOW: begin
        // Rising strobe closes the write
        if (we_rise) begin
          nxt_wr_state = WR_IDLE;
        end
      end
      default: begin
        nxt_wr_state = WR_IDLE;
      end
    endcase
  end

  // Write state register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_state_ff <= WR_IDLE;
    end else begin
      wr_state_ff <= nxt_wr_state;
    end
  end

  // Hold the address while the write strobe is low
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_addr_ff <= FULL_ADDR_RST;
    end else if (wr_state_ff == WR_IDLE && we_fall) begin
      wr_addr_ff <= full_addr;
    end
  end

  // Region check for the held address
  assign top_hit = (wr_addr_ff[BLOCK_LSB +: BLOCK_W] == TOP_BLOCK);
  assign blocked = top_hit ? ~tbl_n_s : ~wp_n_s;

  // Program request or refusal at the end of the write pulse
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prog_valid_o <= 1'b0;
      prog_refused_o <= 1'b0;
      prog_req_o <= '0;
    end else begin
      prog_valid_o <= 1'b0;
      prog_refused_o <= 1'b0;
      if (wr_state_ff == WR_LOW && we_rise) begin
        prog_req_o.addr <= wr_addr_ff;
        prog_req_o.data <= data_s;
        if (blocked) begin
          // Protected region: drop the program and flag it
          prog_refused_o <= 1'b1;
        end else begin
          prog_valid_o <= 1'b1;
        end
      end
    end
  end

  // Data line drivers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte_data_lines_o <= DATA_RST;
      byte_data_lines_oe_o <= 1'b0;
    end else begin
      byte_data_lines_oe_o <= ~oe_n_s;
      byte_data_lines_o <= rd_data_i;
    end
  end

endmodule
